//--- core/dbgc_pkg.sv
/*
 Package for the debug-port CC connection-detect block: states, role
 modes, timing constants and the pin/status carrier structs.
 Assumes a 100 MHz port controller clock.
*/
package dbgc_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS      = 10;
	localparam int DEBOUNCE_TIME_US   = 100;
	localparam int DEBOUNCE_CYCLES    = (DEBOUNCE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TOGGLE_TIME_US     = 50;
	localparam int TOGGLE_CYCLES      = (TOGGLE_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int CNT_W              = 24;

	// ************************************************************
	// Field widths and reset values
	// ************************************************************
	localparam int          CUR_W      = 2;
	localparam logic [1:0]  CUR_RESET  = 2'h0;

	// ************************************************************
	// Role and state encodings
	// ************************************************************
	typedef enum logic [1:0] {
		DBGC_ROLE_SRC,
		DBGC_ROLE_SNK,
		DBGC_ROLE_DRP
	} dbgc_role_t;

	typedef enum logic [2:0] {
		DBGC_UNATT_SRC,
		DBGC_WAIT_SRC,
		DBGC_ATT_SRC,
		DBGC_UNATT_SNK,
		DBGC_WAIT_SNK
	} dbgc_state_t;

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic cc1_pulldown;
		logic cc2_pulldown;
		logic cc1_pullup;
		logic cc2_pullup;
		logic vbus_present;
	} dbgc_sense_t;

	typedef struct packed {
		logic        pullup_en;
		logic        pulldown_en;
		logic [1:0]  pullup_level;
		logic        vbus_en;
		logic        attach_wait;
		logic        attached;
	} dbgc_drive_t;

endpackage

//--- core/dbgc_top.sv
/*
 CC connection-detect logic of a debug test port facing a target port
 without debug accessory support. Sense levels come from analog
 comparators asynchronous to ref_clk_i and are synchronised here.
 Assumes role_i and offer_level_i are static or from ref_clk_i logic.
*/
`timescale 1ns/10ps
module dbgc_top (
	input  wire logic                   ref_clk_i,
	input  wire logic                   reset_i,
	input  wire dbgc_pkg::dbgc_role_t   role_i,
	input  wire logic [1:0]             offer_level_i,
	input  wire dbgc_pkg::dbgc_sense_t  sense_i,
	output dbgc_pkg::dbgc_drive_t       drive_o,
	output dbgc_pkg::dbgc_state_t       state_o
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	dbgc_pkg::dbgc_sense_t sync_a;
	dbgc_pkg::dbgc_sense_t sync_b;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= sense_i;
			sync_b <= sync_a;
		end
	end

	// ************************************************************
	// Decode
	// ************************************************************
	wire logic both_pd   = sync_b.cc1_pulldown & sync_b.cc2_pulldown;
	wire logic both_pu   = sync_b.cc1_pullup & sync_b.cc2_pullup;
	wire logic both_open = ~(sync_b.cc1_pullup | sync_b.cc2_pullup);
	wire logic any_pd    = sync_b.cc1_pulldown | sync_b.cc2_pulldown;

	// ************************************************************
	// State machine
	// ************************************************************
	dbgc_pkg::dbgc_state_t state;
	dbgc_pkg::dbgc_state_t next_state;
	logic [dbgc_pkg::CNT_W-1:0] deb_cnt;
	logic [dbgc_pkg::CNT_W-1:0] next_deb_cnt;
	logic [dbgc_pkg::CNT_W-1:0] tog_cnt;
	logic [dbgc_pkg::CNT_W-1:0] next_tog_cnt;

	localparam logic [dbgc_pkg::CNT_W-1:0] DEB_LAST =
		dbgc_pkg::CNT_W'(dbgc_pkg::DEBOUNCE_CYCLES - 1);
	localparam logic [dbgc_pkg::CNT_W-1:0] TOG_LAST =
		dbgc_pkg::CNT_W'(dbgc_pkg::TOGGLE_CYCLES - 1);

	wire logic is_drp   = (role_i == dbgc_pkg::DBGC_ROLE_DRP);
	wire logic tog_done = (tog_cnt == TOG_LAST);
	wire logic deb_done = (deb_cnt == DEB_LAST);

	always_comb begin
		next_state   = state;
		next_deb_cnt = '0;
		next_tog_cnt = '0;
		case (state)
			dbgc_pkg::DBGC_UNATT_SRC: begin
				next_tog_cnt = tog_cnt + 1'b1;
				if (both_pd) begin
					next_state = dbgc_pkg::DBGC_WAIT_SRC;
				end else if (role_i == dbgc_pkg::DBGC_ROLE_SNK) begin
					next_state = dbgc_pkg::DBGC_UNATT_SNK;
				end else if (is_drp && tog_done) begin
					next_state = dbgc_pkg::DBGC_UNATT_SNK;
				end
			end
			dbgc_pkg::DBGC_WAIT_SRC: begin
				if (!both_pd) begin
					next_state = dbgc_pkg::DBGC_UNATT_SRC;
				end else if (deb_done) begin
					next_state = dbgc_pkg::DBGC_ATT_SRC;
				end else begin
					next_deb_cnt = deb_cnt + 1'b1;
				end
			end
			dbgc_pkg::DBGC_ATT_SRC: begin
				if (!any_pd) begin
					next_state = dbgc_pkg::DBGC_UNATT_SRC;
				end
			end
			dbgc_pkg::DBGC_UNATT_SNK: begin
				next_tog_cnt = tog_cnt + 1'b1;
				if (both_pu) begin
					next_state = dbgc_pkg::DBGC_WAIT_SNK;
				end else if (role_i == dbgc_pkg::DBGC_ROLE_SRC) begin
					next_state = dbgc_pkg::DBGC_UNATT_SRC;
				end else if (is_drp && tog_done) begin
					next_state = dbgc_pkg::DBGC_UNATT_SRC;
				end
			end
			dbgc_pkg::DBGC_WAIT_SNK: begin
				// No VBUS from a far port lacking debug support: stay here
				if (both_open) begin
					next_state = dbgc_pkg::DBGC_UNATT_SNK;
				end
			end
			default: begin
				next_state = dbgc_pkg::DBGC_UNATT_SNK;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state   <= dbgc_pkg::DBGC_UNATT_SNK;
			deb_cnt <= '0;
			tog_cnt <= '0;
		end else begin
			state   <= next_state;
			deb_cnt <= next_deb_cnt;
			tog_cnt <= (next_state != state) ? '0 : next_tog_cnt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	wire logic src_side = (next_state == dbgc_pkg::DBGC_UNATT_SRC) ||
	                      (next_state == dbgc_pkg::DBGC_WAIT_SRC) ||
	                      (next_state == dbgc_pkg::DBGC_ATT_SRC);
	wire logic next_att = (next_state == dbgc_pkg::DBGC_ATT_SRC);

	dbgc_pkg::dbgc_drive_t next_drive;

	always_comb begin
		next_drive              = '0;
		next_drive.pullup_en    = src_side;
		next_drive.pulldown_en  = ~src_side;
		next_drive.pullup_level = next_att ? offer_level_i : dbgc_pkg::CUR_RESET;
		next_drive.vbus_en      = next_att;
		next_drive.attach_wait  = (next_state == dbgc_pkg::DBGC_WAIT_SRC) ||
		                          (next_state == dbgc_pkg::DBGC_WAIT_SNK);
		next_drive.attached     = next_att;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			drive_o <= '0;
			state_o <= dbgc_pkg::DBGC_UNATT_SNK;
		end else begin
			drive_o <= next_drive;
			state_o <= next_state;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_vbus_with_attach: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		drive_o.vbus_en == (state_o == dbgc_pkg::DBGC_ATT_SRC))
		else $error("VBUS enable not tied to attached state");

	a_attach_after_debounce: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == dbgc_pkg::DBGC_WAIT_SRC && next_state == dbgc_pkg::DBGC_ATT_SRC)
		|-> deb_cnt == DEB_LAST)
		else $error("Source attached before debounce elapsed");

	a_debounce_restart: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == dbgc_pkg::DBGC_WAIT_SRC && !both_pd)
		|=> (state == dbgc_pkg::DBGC_UNATT_SRC && deb_cnt == '0))
		else $error("Debounce not restarted on drop");

	a_pullup_level: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == dbgc_pkg::DBGC_ATT_SRC && any_pd && $stable(offer_level_i))
		|=> drive_o.pullup_level == $past(offer_level_i))
		else $error("Pull-up level does not follow offer");

	a_src_detach: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == dbgc_pkg::DBGC_ATT_SRC && !any_pd) |=> state == dbgc_pkg::DBGC_UNATT_SRC)
		else $error("Source detach missed");

	a_snk_wait_entry: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == dbgc_pkg::DBGC_UNATT_SNK && both_pu) |=> state == dbgc_pkg::DBGC_WAIT_SNK)
		else $error("Sink did not enter attach wait");

	a_snk_holds_wait: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == dbgc_pkg::DBGC_WAIT_SNK && !both_open && !sync_b.vbus_present)
		|=> state == dbgc_pkg::DBGC_WAIT_SNK)
		else $error("Sink left attach wait while terminated");

	a_snk_detach: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(state == dbgc_pkg::DBGC_WAIT_SNK && both_open) |=> state == dbgc_pkg::DBGC_UNATT_SNK)
		else $error("Sink detach missed");

	a_drp_toggle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(is_drp && state == dbgc_pkg::DBGC_UNATT_SNK && tog_done && !both_pu)
		|=> state == dbgc_pkg::DBGC_UNATT_SRC)
		else $error("Dual-role toggle missed");

endmodule

//--- verification/dbgc_far_port.sv
/*
 Model of a far target port without debug accessory support.
 Assumes sense levels are open (0) when unplugged.
*/
`timescale 1ns/10ps
module dbgc_far_port #(
	parameter int TOGGLE = 700
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire logic [1:0]            mode_i,
	input  wire logic                  plugged_i,
	input  wire dbgc_pkg::dbgc_drive_t dut_i,
	output dbgc_pkg::dbgc_sense_t      sense_o
);
	logic as_src;
	logic waiting;
	int   cnt;

	always_ff @(posedge clk_i) begin
		if (reset_i || !plugged_i) begin
			waiting <= 1'b0;
			cnt <= 0;
			as_src <= (mode_i == 2'h2) ? (waiting ^ as_src) : (mode_i == 2'h0);
		end else if (!waiting) begin
			if ((as_src && dut_i.pulldown_en) || (!as_src && dut_i.pullup_en)) begin
				waiting <= 1'b1;
			end else if (mode_i == 2'h2 && cnt == TOGGLE) begin
				as_src <= !as_src;
				cnt <= 0;
			end else begin
				cnt <= cnt + 1;
			end
		end
	end

	// Terminations only, no VBUS, never attaches
	always_comb begin
		sense_o = '0;
		sense_o.cc1_pulldown = plugged_i && !as_src;
		sense_o.cc2_pulldown = plugged_i && !as_src;
		sense_o.cc1_pullup = plugged_i && as_src;
		sense_o.cc2_pullup = plugged_i && as_src;
	end
endmodule

//--- verification/dbgc_top_tb.sv
/*
 Self-checking bench for dbgc_top against a far port model.
 Assumes package timing constants.
*/
`timescale 1ns/10ps
module dbgc_top_tb;
	localparam int DEB = dbgc_pkg::DEBOUNCE_CYCLES;
	localparam int TGL = dbgc_pkg::TOGGLE_CYCLES;
	logic                  ref_clk_i = 1'b0;
	logic                  reset_i = 1'b1;
	dbgc_pkg::dbgc_role_t  role_i = dbgc_pkg::DBGC_ROLE_SRC;
	logic [1:0]            offer_level_i = 2'h2;
	logic [1:0]            far_mode = 2'h1;
	logic                  plugged = 1'b0;
	dbgc_pkg::dbgc_sense_t sense_i;
	dbgc_pkg::dbgc_drive_t drive_o;
	dbgc_pkg::dbgc_state_t state_o;
	int                    failures = 0;
	int                    comparisons = 0;
	int                    n;

	always #5 ref_clk_i = ~ref_clk_i;

	dbgc_top dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .role_i(role_i),
		.offer_level_i(offer_level_i), .sense_i(sense_i), .drive_o(drive_o),
		.state_o(state_o));
	dbgc_far_port far (.clk_i(ref_clk_i), .reset_i(reset_i), .mode_i(far_mode),
		.plugged_i(plugged), .dut_i(drive_o), .sense_o(sense_i));

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cycles(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic wait_state(input dbgc_pkg::dbgc_state_t st, input int lim);
		n = 0;
		while (state_o !== st && n < lim) begin
			cycles(1);
			n++;
		end
	endtask

	task automatic restart(input dbgc_pkg::dbgc_role_t r, input logic [1:0] m);
		plugged = 1'b0;
		role_i = r;
		far_mode = m;
		reset_i = 1'b1;
		cycles(2);
		reset_i = 1'b0;
		cycles(2);
	endtask

	task automatic test_src;
		restart(dbgc_pkg::DBGC_ROLE_SRC, 2'h1);
		plugged = 1'b1;
		wait_state(dbgc_pkg::DBGC_WAIT_SRC, 8);
		check("wait latency", 3, n);
		check("attach_wait", 1, drive_o.attach_wait);
		check("pullup_en", 1, drive_o.pullup_en);
		cycles(DEB - 2);
		check("early state", dbgc_pkg::DBGC_WAIT_SRC, state_o);
		wait_state(dbgc_pkg::DBGC_ATT_SRC, 6);
		check("attached", 1, drive_o.attached);
		check("vbus_en", 1, drive_o.vbus_en);
		check("level", 2'h2, drive_o.pullup_level);
		offer_level_i = 2'h1;
		cycles(3);
		check("level new", 2'h1, drive_o.pullup_level);
		plugged = 1'b0;
		wait_state(dbgc_pkg::DBGC_UNATT_SRC, 8);
		check("detach latency", 3, n);
		check("vbus off", 0, drive_o.vbus_en);
		check("level off", 0, drive_o.pullup_level);
		$display("done source");
	endtask

	task automatic test_glitch;
		restart(dbgc_pkg::DBGC_ROLE_SRC, 2'h1);
		plugged = 1'b1;
		cycles(DEB / 2);
		plugged = 1'b0;
		cycles(1);
		plugged = 1'b1;
		cycles(DEB - 2);
		check("restarted", dbgc_pkg::DBGC_WAIT_SRC, state_o);
		wait_state(dbgc_pkg::DBGC_ATT_SRC, 8);
		check("late attach", dbgc_pkg::DBGC_ATT_SRC, state_o);
		$display("done glitch");
	endtask

	task automatic test_snk;
		restart(dbgc_pkg::DBGC_ROLE_SNK, 2'h0);
		plugged = 1'b1;
		wait_state(dbgc_pkg::DBGC_WAIT_SNK, 8);
		check("snk latency", 3, n);
		check("pulldown_en", 1, drive_o.pulldown_en);
		cycles(DEB + 100);
		check("snk held", dbgc_pkg::DBGC_WAIT_SNK, state_o);
		check("snk no attach", 0, drive_o.attached);
		plugged = 1'b0;
		wait_state(dbgc_pkg::DBGC_UNATT_SNK, 8);
		check("snk detach", 3, n);
		$display("done sink");
	endtask

	task automatic test_drp;
		restart(dbgc_pkg::DBGC_ROLE_DRP, 2'h1);
		wait_state(dbgc_pkg::DBGC_UNATT_SRC, TGL + 10);
		wait_state(dbgc_pkg::DBGC_UNATT_SNK, TGL + 10);
		check("toggle", 1, n >= TGL - 2 && n <= TGL + 2);
		plugged = 1'b1;
		wait_state(dbgc_pkg::DBGC_ATT_SRC, DEB + 2 * TGL);
		check("drp source", dbgc_pkg::DBGC_ATT_SRC, state_o);
		restart(dbgc_pkg::DBGC_ROLE_DRP, 2'h2);
		plugged = 1'b1;
		cycles(2 * DEB);
		check("drp forced", 1, state_o === dbgc_pkg::DBGC_ATT_SRC ||
			state_o === dbgc_pkg::DBGC_WAIT_SNK);
		$display("done dual role");
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#950us;
		failures++;
		stop_test();
	end

	initial begin
		test_src();
		test_glitch();
		test_snk();
		test_drp();
		stop_test();
	end
endmodule
